// File: src/ifo_consts.vh
`ifndef IFO_CONSTS_VH
`define IFO_CONSTS_VH

// ==========================================
// register byte offsets
`define IFO_ADDR_CTRL    8'h00
`define IFO_ADDR_OFFSET  8'h04
`define IFO_ADDR_SEL_LO  8'h08
`define IFO_ADDR_SEL_HI  8'h0c
`define IFO_ADDR_STATUS  8'h10
`define IFO_ADDR_OUTFRQ  8'h14

// ==========================================
// control register fields
`define IFO_CTRL_FSRC_LSB  0
`define IFO_CTRL_RSRC_LSB  2
`define IFO_CTRL_DIR_BIT   4
`define IFO_CTRL_MASK      32'h0000_001f

// ==========================================
// selector layout
`define IFO_SEL_W        8
`define IFO_NUM_IN       6

// ==========================================
// codes
`define IFO_OPT_OFFSET   8'h32
`define IFO_OPT_FORCE    8'h33
`define IFO_SRC_TERM     2'h1
`define IFO_DIR_ADD      1'b0

// ==========================================
// reset values
`define IFO_RST_CTRL     5'h00
`define IFO_RST_OFFSET   16'h0000
`define IFO_RST_SEL      8'h00

// ==========================================
// force sequencer states
`define IFO_ST_IDLE      1'b0
`define IFO_ST_STOP      1'b1

`endif

// File: src/ifo_core.v
// Behaviour
// R1: an input whose selector holds code 50 is the offset enable, and while it is on the offset is applied.
// R2: the offset is combined with the frequency setting, as sum or difference, only while that enable is on.
// R3: the direction bit chooses whether the offset is added or subtracted.
// R4: the offset applies whatever frequency source is selected.
// R5: with the enable off the output frequency is the plain setting.
// R6: both functions may be placed on any of the six input selectors.
// R7: an input whose selector holds code 51 forces the frequency source to code 01.
// R8: that same input forces the run command source to code 01.
// R9: the outside party holds the force input to get terminal control until it releases it.
// R10: with force off the stored source selections are used again.
// R11: a force change while the motor runs first stops the motor, then the new state applies.
// R12: a subtraction that would go negative saturates at zero.
`include "ifo_consts.vh"

module ifo_core #(
  parameter FREQ_W = 16
) (
  // apb
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output wire              pready,
  output wire              pslverr,
  output wire [31:0]       prdata,
  // terminals and drive
  input  wire [5:0]        logic_in,
  input  wire [FREQ_W-1:0] cmd_freq,
  input  wire              motor_running,
  // effective settings
  output wire [FREQ_W-1:0] out_freq,
  output wire [1:0]        freq_src_eff,
  output wire [1:0]        run_src_eff,
  output wire              stop_req,
  output wire              force_active
);

  // ==========================================
  // selector decode
  function any_match;
    input [`IFO_NUM_IN*`IFO_SEL_W-1:0] sels;
    input [`IFO_NUM_IN-1:0]            ins;
    input [`IFO_SEL_W-1:0]             code;
    integer i;
    begin
      any_match = 1'b0;
      for (i = 0; i < `IFO_NUM_IN; i = i + 1) begin
        if (ins[i] && sels[i*`IFO_SEL_W +: `IFO_SEL_W] == code) begin
          any_match = 1'b1;
        end
      end
    end
  endfunction

  // ==========================================
  // registers
  reg  [4:0]        ctrl_q;
  reg  [FREQ_W-1:0] offset_q;
  reg  [47:0]       sel_q;
  reg  [31:0]       prdata_q;
  reg  [31:0]       rd_d;
  reg               rd_err;
  reg               st_q;
  reg               force_q;
  reg  [FREQ_W-1:0] freq_q;
  reg  [FREQ_W-1:0] freq_d;
  reg  [FREQ_W:0]   sum;

  wire setup  = psel && !penable;
  wire access = psel && penable;
  wire wr     = access && pwrite;

  wire [1:0] fsrc_user = ctrl_q[`IFO_CTRL_FSRC_LSB +: 2];
  wire [1:0] rsrc_user = ctrl_q[`IFO_CTRL_RSRC_LSB +: 2];
  wire       dir_sub   = ctrl_q[`IFO_CTRL_DIR_BIT] != `IFO_DIR_ADD;

  // any of six inputs may carry either function
  wire ofs_en    = any_match(sel_q, logic_in, `IFO_OPT_OFFSET); // R1 R6
  wire force_raw = any_match(sel_q, logic_in, `IFO_OPT_FORCE);  // R7 R6

  // ==========================================
  // apb register file
  always @* begin
    rd_d   = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `IFO_ADDR_CTRL:   rd_d = {27'h000_0000, ctrl_q};
      `IFO_ADDR_OFFSET: rd_d[FREQ_W-1:0] = offset_q;
      `IFO_ADDR_SEL_LO: rd_d = sel_q[31:0];
      `IFO_ADDR_SEL_HI: rd_d[15:0] = sel_q[47:32];
      `IFO_ADDR_STATUS: rd_d[5:0] = {ofs_en, force_raw, st_q, force_q, motor_running, stop_req};
      `IFO_ADDR_OUTFRQ: rd_d[FREQ_W-1:0] = freq_q;
      default:          rd_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= `IFO_RST_CTRL;
      offset_q <= `IFO_RST_OFFSET;
      sel_q    <= {6{`IFO_RST_SEL}};
      prdata_q <= 32'h0000_0000;
    end else begin
      // read data staged in setup so it comes from a flop
      if (setup) begin
        prdata_q <= rd_d;
      end
      if (wr) begin
        case (paddr)
          `IFO_ADDR_CTRL:   ctrl_q   <= pwdata[4:0];
          `IFO_ADDR_OFFSET: offset_q <= pwdata[FREQ_W-1:0];
          `IFO_ADDR_SEL_LO: sel_q[31:0] <= pwdata;
          `IFO_ADDR_SEL_HI: sel_q[47:32] <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access && rd_err;
  assign prdata  = prdata_q;

  // ==========================================
  // force sequencer
  // a change is never applied mid-drive; source swap under load would jerk the motor
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= `IFO_ST_IDLE;
      force_q <= 1'b0;
    end else begin
      case (st_q)
        `IFO_ST_IDLE: begin
          if (force_raw != force_q) begin
            if (motor_running) begin
              st_q <= `IFO_ST_STOP; // R11
            end else begin
              force_q <= force_raw; // R9
            end
          end
        end
        `IFO_ST_STOP: begin
          if (force_raw == force_q) begin
            st_q <= `IFO_ST_IDLE;
          end else if (!motor_running) begin
            force_q <= force_raw; // R11
            st_q    <= `IFO_ST_IDLE;
          end
        end
        default: st_q <= `IFO_ST_IDLE;
      endcase
    end
  end

  assign stop_req     = st_q == `IFO_ST_STOP; // R11
  assign force_active = force_q;
  assign freq_src_eff = force_q ? `IFO_SRC_TERM : fsrc_user; // R7 R10
  assign run_src_eff  = force_q ? `IFO_SRC_TERM : rsrc_user; // R8 R10

  // ==========================================
  // offset frequency
  // cmd_freq is already the selected source, so any source gets the offset
  always @* begin
    sum    = {1'b0, cmd_freq} + {1'b0, offset_q};
    freq_d = cmd_freq; // R5
    if (ofs_en) begin // R2 R4
      if (dir_sub) begin // R3
        freq_d = (offset_q > cmd_freq) ? {FREQ_W{1'b0}} : cmd_freq - offset_q; // R12
      end else begin
        // top clamps too rather than wrapping
        freq_d = sum[FREQ_W] ? {FREQ_W{1'b1}} : sum[FREQ_W-1:0]; // R1
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q <= {FREQ_W{1'b0}};
    end else begin
      freq_q <= freq_d;
    end
  end

  assign out_freq = freq_q;

endmodule

// File: testbench/ifo_core_properties.sv
module ifo_chk (
  // watched ports
  input logic       pclk,
  input logic       presetn,
  input logic       psel,
  input logic       penable,
  input logic       pwrite,
  input logic       motor_running,
  input logic       stop_req,
  input logic       force_active,
  input logic [1:0] freq_src_eff,
  input logic [1:0] run_src_eff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_force_fsrc: assert property (force_active |-> freq_src_eff == 2'h1) else $error("fsrc");
  a_force_rsrc: assert property (force_active |-> run_src_eff == 2'h1) else $error("rsrc");
  a_wait_hold: assert property (stop_req && motor_running |=> $stable(force_active)) else $error("hold");
  a_run_frozen: assert property ($changed(force_active) |-> !$past(motor_running)) else $error("run");
  a_stop_rise: assert property ($rose(stop_req) |-> $past(motor_running)) else $error("rise");
  a_stop_end: assert property (stop_req && !motor_running |=> !stop_req) else $error("end");
  a_stop_apply: assert property ($changed(force_active) && $past(stop_req) |-> $fell(stop_req)) else $error("apply");
  a_src_cause: assert property ($changed({freq_src_eff, run_src_eff}) |->
    $changed(force_active) || $past(psel && penable && pwrite)) else $error("cause");
endmodule
bind ifo_core ifo_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .motor_running, .stop_req,
  .force_active, .freq_src_eff, .run_src_eff);

// File: testbench/ifo_switch.sv
module ifo_switch (
  // contact command and terminals
  input  logic       pclk,
  input  logic [5:0] close_req,
  output logic [5:0] logic_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial logic_in = 6'h00;
  // contacts follow one clock late, held until released
  always @(posedge pclk) logic_in <= close_req;
endmodule

// File: testbench/ifo_core_tb.sv
`include "ifo_consts.vh"
module ifo_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, motor_running, err, pready, pslverr, stop_req, force_active;
  logic [5:0]  close_req, logic_in;
  logic [7:0]  paddr;
  logic [15:0] cmd_freq, off, out_freq;
  logic [31:0] pwdata, prdata, rd, ctl, seed = 32'hdac7_4945;
  logic [47:0] sel;
  logic [1:0]  freq_src_eff, run_src_eff;
  int          errors = 0, num_checks = 0, ka, kf;
  ifo_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .logic_in, .cmd_freq, .motor_running, .out_freq, .freq_src_eff, .run_src_eff, .stop_req, .force_active);
  ifo_switch i_sw (.pclk, .close_req, .logic_in);
  always #25 pclk = ~pclk;
  // ======
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] exp_f(logic [15:0] c, logic [15:0] o, logic sub);
    logic [16:0] s;
    s = sub ? {1'b0, c} - {1'b0, o} : {1'b0, c} + {1'b0, o};
    // clamp, never wrap
    return s[16] ? (sub ? 16'h0000 : 16'hffff) : s[15:0];
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      errors++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  // ======
  // main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, motor_running, close_req, cmd_freq, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, err);
    chk("unmapped", 32'h0000_0000, rd);
    for (int i = 0; i < 8; i++) begin
      ka = rnd() % 6;
      kf = (ka + 1 + rnd() % 5) % 6;
      sel = '0;
      sel[ka*8+:8] = `IFO_OPT_OFFSET;
      sel[kf*8+:8] = `IFO_OPT_FORCE;
      ctl = rnd() & `IFO_CTRL_MASK;
      off = i == 1 ? 16'hffff : 16'(rnd());
      apb(1'b1, `IFO_ADDR_CTRL, ctl);
      apb(1'b1, `IFO_ADDR_OFFSET, {16'h0000, off});
      apb(1'b1, `IFO_ADDR_SEL_LO, sel[31:0]);
      apb(1'b1, `IFO_ADDR_SEL_HI, {16'h0000, sel[47:32]});
      @(posedge pclk);
      cmd_freq <= i == 0 ? 16'h0000 : 16'(rnd());
      close_req <= 6'h01 << ka;
      tick(2);
      chk("out", exp_f(cmd_freq, off, ctl[4]), out_freq);
      @(posedge pclk);
      close_req <= 6'h01 << kf;
      tick(2);
      chk("plain", cmd_freq, out_freq);
      chk("forced", 5'h15, {force_active, run_src_eff, freq_src_eff});
      @(posedge pclk);
      motor_running <= 1'b1;
      close_req <= 6'h00;
      tick(2);
      chk("stopping", 5'h15, {stop_req, run_src_eff, freq_src_eff});
      @(posedge pclk);
      motor_running <= 1'b0;
      tick(2);
      chk("released", {1'b0, ctl[3:0]}, {stop_req, run_src_eff, freq_src_eff});
      $display("test %0d done", i);
    end
    report_and_stop();
  end
endmodule
